/* dv/ctrl_model.sv */
// display controller model
`timescale 1ns/10ps
module ctrl_model (
  input wire logic mclk,
  output logic [3:0] pins
);
  initial pins = 4'h1;
  task step(input logic [3:0] v);
    @(posedge mclk) pins <= v;
    repeat (7) @(posedge mclk);
  endtask
  task burst(input int n, input logic [15:0] w, input logic [1:0] lo);
    for (int i = n - 1; i >= 0; i--) begin
      step({1'b0, w[i], lo});
      step({1'b1, w[i], lo});
    end
  endtask
endmodule

/* dv/led_sink_chk_assertions.sv */
// port checker
`timescale 1ns/10ps
module led_sink_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic drive_enable_low,
  input wire logic [15:0] led_sink_outputs,
  input wire logic lowCurrentMode,
  input wire logic errorModeActive,
  input wire logic testTimeMet
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_oen_gate: assert property (drive_enable_low[*8] |-> !led_sink_outputs) else $error("lit");
  a_lit_cause: assert property ($rose(|led_sink_outputs) |-> !$past(drive_enable_low, 3)) else $error("lit");
  a_err_entry: assert property ($rose(errorModeActive) |-> $past(drive_enable_low, 3)) else $error("entry");
  a_lowcur_err: assert property ($rose(lowCurrentMode) |-> errorModeActive) else $error("mode");
  a_test_time: assert property ($rose(testTimeMet) |-> errorModeActive) else $error("timer");
  a_lowcur_exit: assert property ($fell(errorModeActive) |-> !lowCurrentMode) else $error("exit");
  cover property (errorModeActive);
  cover property (lowCurrentMode);
  cover property (|led_sink_outputs);
endmodule
bind led_sink_shift_diag_port led_sink_chk i_chk (.*);

/* dv/led_sink_shift_diag_port_test.sv */
// led sink port bench
`timescale 1ns/10ps
module led_sink_shift_diag_port_test;
  logic mclk = 1'h0, rst_n = 1'h0, loadStrobeDriven = 1'h1, driveEnableLowDriven = 1'h1;
  logic [15:0] openSense = 16'h0, shortSense = 16'h0, led_sink_outputs;
  logic overTempSense = 1'h0, serial_out, lowCurrentMode, shortThreshLevel2, errorModeActive, testTimeMet;
  wire logic [3:0] pins;
  int mismatches = 0, tests_run = 0, cycles = 0;
  always #2 mclk = ~mclk;
  ctrl_model i_ctrl (.*); // model feeds the four control pins
  led_sink_shift_diag_port i_dut (.shiftClk(pins[3]), .serial_in(pins[2]), .load_strobe(pins[1]),
    .drive_enable_low(pins[0]), .*);
  task check(input logic [15:0] got, exp);
    #1 tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t %h %h", $time, got, exp);
    end
  endtask
  task results();
    $display("errors %0d checks %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk) if (++cycles == 9000) begin
    mismatches++;
    results();
  end
  task display_test();
    i_ctrl.burst(16, 16'ha5c3, 2'b00);
    i_ctrl.step(4'h2);
    check(led_sink_outputs, 16'ha5c3);
    check(16'(serial_out), 16'h1);
    i_ctrl.burst(16, 16'h5a3c, 2'b00);
    check(led_sink_outputs, 16'ha5c3);
  endtask
  task float_test();
    i_ctrl.step(4'h0);
    driveEnableLowDriven <= 1'h0;
    i_ctrl.step(4'h0);
    check(led_sink_outputs, 16'h0);
    driveEnableLowDriven <= 1'h1;
    loadStrobeDriven <= 1'h0;
    i_ctrl.step(4'h2);
    i_ctrl.step(4'h0);
    check(led_sink_outputs, 16'ha5c3);
    loadStrobeDriven <= 1'h1;
  endtask
  task lowcur_test();
    i_ctrl.step(4'h1);
    i_ctrl.step(4'h3);
    i_ctrl.burst(3, 16'hffff, 2'b11);
    check(16'({errorModeActive, testTimeMet, lowCurrentMode}), 16'h5);
    i_ctrl.step(4'h5);
    check(16'({errorModeActive, lowCurrentMode}), 16'h0);
  endtask
  task open_test();
    i_ctrl.step(4'h3);
    i_ctrl.burst(1, 16'hffff, 2'b11);
    openSense <= 16'h0004;
    i_ctrl.step(4'h6);
    repeat (510) @(posedge mclk);
    check(led_sink_outputs, 16'h5a3c);
    check(16'({errorModeActive, testTimeMet, lowCurrentMode, serial_out}), 16'hd);
    i_ctrl.step(4'h7);
    check(16'(serial_out), 16'h0);
    i_ctrl.step(4'h4);
    openSense <= 16'h0;
    i_ctrl.burst(7, 16'h0, 2'b00);
    check(16'(serial_out), 16'h0);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    display_test();
    float_test();
    lowcur_test();
    open_test();
    results();
  end
endmodule

/* verilog/diag_capture.sv */
// fault comparator sampling and per-channel diagnostic result store
`timescale 1ns/10ps
module diag_capture (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic capture,
  input wire logic [15:0] ledOn,
  input wire logic [15:0] openSense,
  input wire logic [15:0] shortSense,
  input wire logic overTempSense,
  output logic [15:0] tempDetail,
  output logic [15:0] openDetail,
  output logic [15:0] shortDetail
);
  logic [32:0] s1_q, s2_q, s3_q; // sense sync chain
  logic [32:0] sen_q, sen_d; // filtered sense levels, one means fault
  logic [15:0] temp_q, temp_d, open_q, open_d, short_q, short_d;

  // filter, then capture results on drive enable rising
  always_comb begin
    sen_d = (s2_q & s3_q) | (sen_q & (s2_q | s3_q));
    temp_d = temp_q;
    open_d = open_q;
    short_d = short_q;
    if (capture) begin
      // zero marks a fault; dark channels cannot fail open or short and read one there, while temperature marks every channel
      temp_d = {16{~sen_q[32]}};
      open_d = ~(sen_q[15:0] & ledOn);
      short_d = ~(sen_q[31:16] & ledOn);
    end
  end

  // result and sync registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sen_q <= '0;
      temp_q <= led_sink_pkg::DETAIL_RST;
      open_q <= led_sink_pkg::DETAIL_RST;
      short_q <= led_sink_pkg::DETAIL_RST;
    end else begin
      s1_q <= {overTempSense, shortSense, openSense};
      s2_q <= s1_q;
      s3_q <= s2_q;
      sen_q <= sen_d;
      temp_q <= temp_d;
      open_q <= open_d;
      short_q <= short_d;
    end
  end

  assign tempDetail = temp_q;
  assign openDetail = open_q;
  assign shortDetail = short_q;
endmodule

/* verilog/led_sink_pkg.sv */
// shared constants and types for the led sink shift port
package led_sink_pkg;

  // channel count and shift geometry
  localparam int CHANNELS = 16;
  // shift bit that feeds the serial output on the falling shift edge
  localparam int SO_TAP = 8;

  // bit positions of the synchronised control pins
  localparam int PIN_SCLK = 0;
  localparam int PIN_SDI = 1;
  localparam int PIN_LOAD = 2;
  localparam int PIN_OEN = 3;
  localparam int PIN_COUNT = 4;

  // reset levels of the synchronised pins: drive enable idles high
  localparam logic [3:0] PIN_RST = 4'h8;

  // register reset values
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] DETAIL_RST = 16'hffff;
  localparam logic FLAG_RST = 1'b1;
  localparam logic SDO_RST = 1'b0;

  // pulse counts selecting a global error test
  localparam logic [2:0] SEL_TEMP = 3'h0;
  localparam logic [2:0] SEL_OPEN = 3'h1;
  localparam logic [2:0] SEL_SHORT = 3'h2;
  localparam logic [2:0] SEL_LOWCUR = 3'h3;
  localparam logic [2:0] SEL_THRESH = 3'h4;

  // least drive enable low time during a test
  localparam int CLK_MHZ = 250;
  localparam int TESTING_NS = 2000;
  localparam int TESTING_CYC = (TESTING_NS * CLK_MHZ + 999) / 1000;
  localparam int TEST_CNT_W = $clog2(TESTING_CYC + 1);

  // operating mode of the port
  typedef enum logic {MODE_NORMAL, MODE_ERROR} mode_e;

endpackage

/* verilog/led_sink_shift_diag_port.sv */
// serial shift front end of a sixteen channel led sink driver with diagnostics
`timescale 1ns/10ps
module led_sink_shift_diag_port (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic shiftClk,
  input wire logic serial_in,
  input wire logic load_strobe,
  input wire logic loadStrobeDriven,
  input wire logic drive_enable_low,
  input wire logic driveEnableLowDriven,
  input wire logic [15:0] openSense,
  input wire logic [15:0] shortSense,
  input wire logic overTempSense,
  output logic [15:0] led_sink_outputs,
  output logic serial_out,
  output logic lowCurrentMode,
  output logic shortThreshLevel2,
  output logic errorModeActive,
  output logic testTimeMet
);

  // pin defaults and synchroniser feed

  // drive enable as seen behind its pull-up
  logic oenPin;
  // load strobe as seen behind its pull-down
  logic loadPin;
  // raw pin word into the three stage filter
  logic [led_sink_pkg::PIN_COUNT-1:0] pinRaw;

  // filtered levels and one-cycle edge pulses
  pin_if pins ();

  // shift clock rising, sampled once per edge
  logic sclkRise;
  // shift clock falling, moves the serial output
  logic sclkFall;
  // shift clock level, must be low at test entry
  logic sclkLvl;
  // serial input level at the current edge
  logic sdiLvl;
  // load strobe rising
  logic loadRise;
  // load strobe falling
  logic loadFall;
  // drive enable level, high means outputs off
  logic oenLvl;
  // drive enable rising, ends a diagnostic test
  logic oenRise;

  // per-channel results, zero marks a fault
  logic [15:0] tempDetail;
  logic [15:0] openDetail;
  logic [15:0] shortDetail;

  // strobe into the result store
  logic diagCapture;
  // global result of the selected test, one when clean
  logic globalFlag;

  // mode and test selection state
  led_sink_pkg::mode_e mode_q, mode_d;
  // pulse count since test entry
  logic [2:0] sel_q, sel_d;
  // low current diagnostic running
  logic lowCur_q, lowCur_d;
  // short threshold at its second level
  logic thresh2_q, thresh2_d;
  // registered copy of the mode for the port
  logic errAct_q, errAct_d;

  // serial shift register, bit zero takes the input
  logic [15:0] shift_q, shift_d;
  // displayed pattern, apart from the shift register
  logic [15:0] data_q, data_d;

  // sink outputs after the drive enable gate
  logic [15:0] ledOut_q, ledOut_d;
  // serial output flip-flop
  logic sdo_q, sdo_d;

  // cycles of drive enable low during a test
  logic [led_sink_pkg::TEST_CNT_W-1:0] testCnt_q, testCnt_d;
  // least testing time reached
  logic testMet_q, testMet_d;

  // detail word of a selection; other selections carry none
  function automatic logic [15:0] selDetail(
    input logic [2:0] sel,
    input logic [15:0] t,
    input logic [15:0] o,
    input logic [15:0] s
  );
    case (sel)
      led_sink_pkg::SEL_TEMP: selDetail = t;
      led_sink_pkg::SEL_OPEN: selDetail = o;
      led_sink_pkg::SEL_SHORT: selDetail = s;
      default: selDetail = 16'hffff;
    endcase
  endfunction

  // true where a selection has a per-channel report
  function automatic logic hasDetail(input logic [2:0] sel);
    hasDetail = (sel <= led_sink_pkg::SEL_SHORT);
  endfunction

  // load strobe reads low when undriven
  assign loadPin = loadStrobeDriven ? load_strobe : 1'b0;
  // drive enable reads high when undriven
  assign oenPin = driveEnableLowDriven ? drive_enable_low : 1'b1;

  // pin word in the order of the package positions
  assign pinRaw = {oenPin, loadPin, serial_in, shiftClk};

  // every pin is asynchronous to mclk, so all pass the filter
  pin_sync i_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinRaw(pinRaw),
    .pins(pins)
  );

  // unpack the filtered pins
  assign sclkRise = pins.rise[led_sink_pkg::PIN_SCLK];
  assign sclkFall = pins.fall[led_sink_pkg::PIN_SCLK];
  assign sclkLvl = pins.lvl[led_sink_pkg::PIN_SCLK];
  assign sdiLvl = pins.lvl[led_sink_pkg::PIN_SDI];
  assign loadRise = pins.rise[led_sink_pkg::PIN_LOAD];
  assign loadFall = pins.fall[led_sink_pkg::PIN_LOAD];
  assign oenLvl = pins.lvl[led_sink_pkg::PIN_OEN];
  assign oenRise = pins.rise[led_sink_pkg::PIN_OEN];

  // results are taken when drive enable rises in error mode;
  // only lit channels can be judged, so data_q marks them
  assign diagCapture = oenRise && (mode_q == led_sink_pkg::MODE_ERROR);

  diag_capture i_diag (
    .mclk(mclk),
    .rst_n(rst_n),
    .capture(diagCapture),
    .ledOn(data_q),
    .openSense(openSense),
    .shortSense(shortSense),
    .overTempSense(overTempSense),
    .tempDetail(tempDetail),
    .openDetail(openDetail),
    .shortDetail(shortDetail)
  );

  // global flag is the and of the detail word
  assign globalFlag = hasDetail(sel_q) ? &selDetail(sel_q, tempDetail, openDetail, shortDetail) : 1'b1;

  // mode and selection: next values
  always_comb begin
    mode_d = mode_q;
    sel_d = sel_q;
    lowCur_d = lowCur_q;
    thresh2_d = thresh2_q;
    case (mode_q)
      led_sink_pkg::MODE_NORMAL: begin
        // load rise, enable high, clock low
        if (loadRise && oenLvl && !sclkLvl) begin
          mode_d = led_sink_pkg::MODE_ERROR;
          sel_d = led_sink_pkg::SEL_TEMP;
          lowCur_d = 1'b0;
        end
      end
      led_sink_pkg::MODE_ERROR: begin
        if (loadFall) begin
          // leaving the test also ends the low current mode
          mode_d = led_sink_pkg::MODE_NORMAL;
          lowCur_d = 1'b0;
        end else if (sclkRise) begin
          // count saturates at the threshold step
          if (sel_q != led_sink_pkg::SEL_THRESH) begin
            sel_d = sel_q + 3'h1;
          end
          // fourth pulse takes the inverted level of the input
          if (sel_q == led_sink_pkg::SEL_LOWCUR) begin
            thresh2_d = !sdiLvl;
          end
          // third pulse starts low current mode
          lowCur_d = (sel_q == led_sink_pkg::SEL_SHORT);
        end
      end
      default: begin
        mode_d = led_sink_pkg::MODE_NORMAL;
      end
    endcase
    // port copy follows the next mode, so both move together
    errAct_d = (mode_d == led_sink_pkg::MODE_ERROR);
  end

  // mode and selection registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= led_sink_pkg::MODE_NORMAL;
      sel_q <= led_sink_pkg::SEL_TEMP;
      lowCur_q <= 1'b0;
      thresh2_q <= 1'b0;
      errAct_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      sel_q <= sel_d;
      lowCur_q <= lowCur_d;
      thresh2_q <= thresh2_d;
      errAct_q <= errAct_d;
    end
  end

  // shift and data registers: next values
  always_comb begin
    shift_d = shift_q;
    data_d = data_q;
    // clock rise shifts input into bit zero
    if ((mode_q == led_sink_pkg::MODE_NORMAL) && sclkRise) begin
      shift_d = {shift_q[14:0], sdiLvl};
    end
    // load fall loads the selected report
    if ((mode_q == led_sink_pkg::MODE_ERROR) && loadFall && hasDetail(sel_q)) begin
      shift_d = selDetail(sel_q, tempDetail, openDetail, shortDetail);
    end
    // load rise copies shift into data
    if (loadRise) begin
      data_d = shift_q;
    end
  end

  // data held apart from the shift register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= led_sink_pkg::SHIFT_RST;
      data_q <= led_sink_pkg::DATA_RST;
    end else begin
      shift_q <= shift_d;
      data_q <= data_d;
    end
  end

  // outputs: next values
  always_comb begin
    // enable high turns every sink off
    ledOut_d = oenLvl ? 16'h0000 : data_q;
    sdo_d = sdo_q;
    if (mode_q == led_sink_pkg::MODE_ERROR) begin
      // flag gated with the chain input
      sdo_d = globalFlag & sdiLvl;
    end else if (sclkFall) begin
      // falling edge after tap eight is 8.5
      sdo_d = shift_q[led_sink_pkg::SO_TAP];
    end
  end

  // output flip-flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ledOut_q <= 16'h0000;
      sdo_q <= led_sink_pkg::SDO_RST;
    end else begin
      ledOut_q <= ledOut_d;
      sdo_q <= sdo_d;
    end
  end

  // testing time: next values; a break in the low level restarts the count
  always_comb begin
    testCnt_d = testCnt_q;
    testMet_d = testMet_q;
    if (mode_d != led_sink_pkg::MODE_ERROR) begin
      testCnt_d = '0;
      testMet_d = 1'b0;
    end else if (!oenLvl) begin
      // count enable low time during a test
      if (int'(testCnt_q) < led_sink_pkg::TESTING_CYC) begin
        testCnt_d = testCnt_q + 1'b1;
      end else begin
        testMet_d = 1'b1;
      end
    end else begin
      testCnt_d = '0;
    end
  end

  // testing time registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      testCnt_q <= '0;
      testMet_q <= 1'b0;
    end else begin
      testCnt_q <= testCnt_d;
      testMet_q <= testMet_d;
    end
  end

  // every output straight from a flip-flop
  assign led_sink_outputs = ledOut_q;
  assign serial_out = sdo_q;
  assign lowCurrentMode = lowCur_q;
  assign shortThreshLevel2 = thresh2_q;
  assign errorModeActive = errAct_q;
  assign testTimeMet = testMet_q;
endmodule

/* verilog/pin_if.sv */
// synchronised pin levels and edge pulses between the pin stage and the core
`timescale 1ns/10ps
interface pin_if;
  logic [led_sink_pkg::PIN_COUNT-1:0] lvl; // filtered level
  logic [led_sink_pkg::PIN_COUNT-1:0] rise; // one-cycle rising pulse
  logic [led_sink_pkg::PIN_COUNT-1:0] fall; // one-cycle falling pulse
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

/* verilog/pin_sync.sv */
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module pin_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [led_sink_pkg::PIN_COUNT-1:0] pinRaw,
  pin_if.src pins
);
  localparam int W = led_sink_pkg::PIN_COUNT;

  logic [W-1:0] s1_q, s2_q, s3_q; // sync chain, s1 feeds only s2
  logic [W-1:0] lvl_q, lvl_d; // accepted level
  logic [W-1:0] rise_q, rise_d, fall_q, fall_d; // edge pulses

  // level moves only when stages two and three agree
  always_comb begin
    lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    rise_d = lvl_d & ~lvl_q;
    fall_d = ~lvl_d & lvl_q;
  end

  // register chain, level and pulses
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= led_sink_pkg::PIN_RST;
      s2_q <= led_sink_pkg::PIN_RST;
      s3_q <= led_sink_pkg::PIN_RST;
      lvl_q <= led_sink_pkg::PIN_RST;
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      s1_q <= pinRaw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign pins.lvl = lvl_q;
  assign pins.rise = rise_q;
  assign pins.fall = fall_q;
endmodule
